// ==== inc/tx_slot_map_regs.vh ====
/*
  register offsets, field positions, reset values and frame constants
  for the transmit channel 4 to 6 source and slot mapping block.
  assumes it is included by bare name from the design files only.
*/
`ifndef TX_SLOT_MAP_REGS_VH
`define TX_SLOT_MAP_REGS_VH

// register offsets on the control port
`define TX_CH4_SOURCE_SLOT_ADDR 8'h21
`define TX_CH5_SOURCE_SLOT_ADDR 8'h22
`define TX_CH6_SOURCE_SLOT_ADDR 8'h23

// reset values
`define TX_CH4_SOURCE_SLOT_RST 8'h03
`define TX_CH5_SOURCE_SLOT_RST 8'h04
`define TX_CH6_SOURCE_SLOT_RST 8'h05
`define UNMAPPED_READ_VALUE 8'h00

// field positions
`define RESERVED_BIT 7
`define SOURCE_SELECT_MSB 6
`define SOURCE_SELECT_LSB 5
`define SLOT_NUMBER_MSB 4
`define SLOT_NUMBER_LSB 0
`define WRITE_MASK 8'h7F

// source select encodings
`define SRC_SEL_HIZ 2'h0
`define SRC_SEL_FIRST 2'h1
`define SRC_SEL_SECOND 2'h2
`define SRC_SEL_RESERVED 2'h3

// serial format encodings on the MODE input
`define MODE_TDM 2'h0
`define MODE_I2S 2'h1
`define MODE_LJ 2'h2

// frame geometry: 32 bit slots, bit counter with an overflow bit
`define WORD_BITS 32
`define SLOT_BITS_LOG2 5
`define BIT_CNT_WIDTH 11
`define BIT_CNT_ZERO 11'h000
`define BIT_CNT_ONE 11'h001
`define HALF_SLOTS 16

`endif

// ==== rtl/tx_word_buffer.v ====
/*
  two-entry buffer with valid and ready on both sides.
  assumes both sides run on the same clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none

module tx_word_buffer #(
  parameter WIDTH = 192
) (
  // clock and reset
  input wire clk,
  input wire srst,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem [0:1];
  reg wr_ptr_reg;
  reg rd_ptr_reg;
  reg [1:0] count_reg;
  wire push;
  wire pop;

  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      case ({push, pop})
        2'b10: count_reg <= count_reg + 2'h1;
        2'b01: count_reg <= count_reg - 2'h1;
        default: count_reg <= count_reg;
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== rtl/serial_tx_channel_slot_map.v ====
/*
  transmit channels 4 to 6 of the primary serial port: source select and
  slot placement registers, and a serializer that drives each channel's
  word in its slot on one shared data line.
  assumes the bit clock and frame sync come from the far side on pins,
  that source words and MODE come from logic on SYS_CLK, and that the bit
  clock is slow enough to be sampled by SYS_CLK (at least 4 cycles a half).
*/
// Functional notes
// - ch4 select: hiz, mic ch4, temperature, reserved
// - ch4 slot field bits 4-0, reset 3
// - ch5 select: hiz, loopback in1, echo ref 1
// - ch5 slot field bits 4-0, reset 4
// - ch6 register: select resets 0, slot 5
// - bit 7 reserved, reads zero, written zero
// - select zero leaves channel output undriven
// - ch6 select: loopback in2, echo ref 2
`timescale 1ns/1ps
`default_nettype none
`include "tx_slot_map_regs.vh"

module serial_tx_channel_slot_map (
  // clock and reset
  input wire SYS_CLK,
  input wire SRST,
  // register port
  input wire REG_WE,
  input wire REG_RE,
  input wire [7:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  output reg [7:0] REG_RDATA,
  // serial format
  input wire [1:0] MODE,
  // source words
  input wire SRC_VALID,
  output reg SRC_READY,
  input wire [31:0] SRC_MIC4,
  input wire [31:0] SRC_TEMP,
  input wire [31:0] SRC_LOOP1,
  input wire [31:0] SRC_LOOP2,
  input wire [31:0] SRC_ECHO1,
  input wire [31:0] SRC_ECHO2,
  // serial link pins
  input wire BCLK,
  input wire FSYNC,
  output reg DOUT,
  output reg DOUT_OE
);

  // registers
  reg [7:0] ch4_cfg_reg;
  reg [7:0] ch5_cfg_reg;
  reg [7:0] ch6_cfg_reg;

  // pin synchronisers
  reg bclk_s1_reg;
  reg bclk_s2_reg;
  reg bclk_s3_reg;
  reg fs_s1_reg;
  reg fs_s2_reg;
  reg fs_s3_reg;
  reg bclk_f_reg;
  reg bclk_d_reg;
  reg fs_f_reg;
  reg fs_last_reg;

  // frame state
  reg [`BIT_CNT_WIDTH-1:0] cnt_reg;
  reg dly_reg;
  reg right_reg;
  reg started_reg;
  reg [191:0] cur_reg;

  wire bclk_rise;
  wire bclk_fall;
  wire fs_edge;
  wire frame_start;
  wire restart;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [191:0] buf_out_data;
  wire buf_pop;

  reg hit4;
  reg hit5;
  reg hit6;
  reg dout_next;
  reg oe_next;

  function [7:0] cfg_write;
    input [7:0] wdata;
    begin
      cfg_write = wdata & `WRITE_MASK;
    end
  endfunction

  // true while the bit counter lies in the channel's slot
  function slot_hit;
    input [4:0] slot;
    input [1:0] mode;
    input right;
    input [`BIT_CNT_WIDTH-1:0] cnt;
    begin
      if (mode == `MODE_TDM) begin
        slot_hit = (cnt[`BIT_CNT_WIDTH-1] == 1'b0) && (cnt[9:5] == slot);
      end else begin
        slot_hit = (cnt[`BIT_CNT_WIDTH-1:9] == 2'b00) && ({right, cnt[8:5]} == slot);
      end
    end
  endfunction

  // bit of the selected source word, msb first
  function pick_bit;
    input [1:0] sel;
    input [31:0] first;
    input [31:0] second;
    input [4:0] bitpos;
    begin
      case (sel)
        `SRC_SEL_FIRST: pick_bit = first[5'h1F - bitpos];
        `SRC_SEL_SECOND: pick_bit = second[5'h1F - bitpos];
        default: pick_bit = 1'b0;
      endcase
    end
  endfunction

  // selects 0 and 3 never drive the line
  function sel_drives;
    input [1:0] sel;
    begin
      sel_drives = (sel == `SRC_SEL_FIRST) || (sel == `SRC_SEL_SECOND);
    end
  endfunction

  // true while a channel with this config owns the present bit
  function chan_hit;
    input [7:0] cfg;
    input started;
    input dly;
    input [1:0] mode;
    input right;
    input [`BIT_CNT_WIDTH-1:0] cnt;
    begin
      chan_hit = started && !dly && sel_drives(cfg[6:5]) &&
                 slot_hit(cfg[4:0], mode, right, cnt);
    end
  endfunction

  // register file
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      ch4_cfg_reg <= `TX_CH4_SOURCE_SLOT_RST;
      ch5_cfg_reg <= `TX_CH5_SOURCE_SLOT_RST;
      ch6_cfg_reg <= `TX_CH6_SOURCE_SLOT_RST;
      REG_RDATA <= `UNMAPPED_READ_VALUE;
    end else begin
      if (REG_WE) begin
        case (REG_ADDR)
          `TX_CH4_SOURCE_SLOT_ADDR: ch4_cfg_reg <= cfg_write(REG_WDATA);
          `TX_CH5_SOURCE_SLOT_ADDR: ch5_cfg_reg <= cfg_write(REG_WDATA);
          `TX_CH6_SOURCE_SLOT_ADDR: ch6_cfg_reg <= cfg_write(REG_WDATA);
          default: ;
        endcase
      end
      if (REG_RE) begin
        case (REG_ADDR)
          `TX_CH4_SOURCE_SLOT_ADDR: REG_RDATA <= ch4_cfg_reg;
          `TX_CH5_SOURCE_SLOT_ADDR: REG_RDATA <= ch5_cfg_reg;
          `TX_CH6_SOURCE_SLOT_ADDR: REG_RDATA <= ch6_cfg_reg;
          default: REG_RDATA <= `UNMAPPED_READ_VALUE;
        endcase
      end
    end
  end

  // three-stage synchronisers; a level counts once stages two and three agree
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      bclk_s1_reg <= 1'b0;
      bclk_s2_reg <= 1'b0;
      bclk_s3_reg <= 1'b0;
      fs_s1_reg <= 1'b0;
      fs_s2_reg <= 1'b0;
      fs_s3_reg <= 1'b0;
      bclk_f_reg <= 1'b0;
      bclk_d_reg <= 1'b0;
      fs_f_reg <= 1'b0;
    end else begin
      bclk_s1_reg <= BCLK;
      bclk_s2_reg <= bclk_s1_reg;
      bclk_s3_reg <= bclk_s2_reg;
      fs_s1_reg <= FSYNC;
      fs_s2_reg <= fs_s1_reg;
      fs_s3_reg <= fs_s2_reg;
      if (bclk_s2_reg == bclk_s3_reg) begin
        bclk_f_reg <= bclk_s3_reg;
      end
      if (fs_s2_reg == fs_s3_reg) begin
        fs_f_reg <= fs_s3_reg;
      end
      bclk_d_reg <= bclk_f_reg;
    end
  end

  assign bclk_rise = bclk_f_reg & ~bclk_d_reg;
  assign bclk_fall = ~bclk_f_reg & bclk_d_reg;
  assign fs_edge = bclk_rise & (fs_f_reg != fs_last_reg);
  // a frame opens on frame sync rising, or falling for i2s (left half low)
  assign frame_start = fs_edge & ((MODE == `MODE_I2S) ? ~fs_f_reg : fs_f_reg);
  // tdm counts across the whole frame; i2s, lj and the unused mode 3 restart for the right half
  assign restart = fs_edge & (frame_start | (MODE != `MODE_TDM));
  assign buf_pop = frame_start;

  tx_word_buffer #(
    .WIDTH(192)
  ) u_buf (
    .clk(SYS_CLK),
    .srst(SRST),
    .in_valid(SRC_VALID),
    .in_ready(buf_in_ready),
    .in_data({SRC_MIC4, SRC_TEMP, SRC_LOOP1, SRC_LOOP2, SRC_ECHO1, SRC_ECHO2}),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out_data)
  );

  // frame position, counted on bit clock rising edges
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      fs_last_reg <= 1'b0;
      cnt_reg <= {1'b1, 10'h000};
      dly_reg <= 1'b0;
      right_reg <= 1'b0;
      started_reg <= 1'b0;
      cur_reg <= 192'h0;
      SRC_READY <= 1'b0;
    end else begin
      SRC_READY <= buf_in_ready;
      if (bclk_rise) begin
        fs_last_reg <= fs_f_reg;
        if (restart) begin
          cnt_reg <= `BIT_CNT_ZERO;
          dly_reg <= (MODE == `MODE_I2S);
          right_reg <= ~frame_start;
          if (frame_start) begin
            started_reg <= 1'b1;
            cur_reg <= buf_out_valid ? buf_out_data : 192'h0;
          end
        end else if (dly_reg) begin
          dly_reg <= 1'b0;
        end else if (cnt_reg[`BIT_CNT_WIDTH-1] == 1'b0) begin
          cnt_reg <= cnt_reg + `BIT_CNT_ONE;
        end
      end
    end
  end

  // which channel owns the present bit; channel 4 wins a shared slot
  always @* begin
    hit4 = chan_hit(ch4_cfg_reg, started_reg, dly_reg, MODE, right_reg, cnt_reg);
    hit5 = chan_hit(ch5_cfg_reg, started_reg, dly_reg, MODE, right_reg, cnt_reg);
    hit6 = chan_hit(ch6_cfg_reg, started_reg, dly_reg, MODE, right_reg, cnt_reg);
    dout_next = 1'b0;
    oe_next = 1'b0;
    if (hit4) begin
      dout_next = pick_bit(ch4_cfg_reg[6:5], cur_reg[191:160], cur_reg[159:128], cnt_reg[4:0]);
      oe_next = 1'b1;
    end else if (hit5) begin
      dout_next = pick_bit(ch5_cfg_reg[6:5], cur_reg[127:96], cur_reg[63:32], cnt_reg[4:0]);
      oe_next = 1'b1;
    end else if (hit6) begin
      dout_next = pick_bit(ch6_cfg_reg[6:5], cur_reg[95:64], cur_reg[31:0], cnt_reg[4:0]);
      oe_next = 1'b1;
    end
  end

  // line changes on bit clock falling edges so the far side samples on rising
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      DOUT <= 1'b0;
      DOUT_OE <= 1'b0;
    end else if (bclk_fall) begin
      DOUT <= dout_next;
      DOUT_OE <= oe_next;
    end
  end

endmodule

`default_nettype wire

// ==== testbench/slot_map_props.sv ====
/* port checks for the transmit slot map
   assumes bit clock halves of at least 4 SYS_CLK cycles */
`timescale 1ns/1ps
`default_nettype none
module slot_map_props (
  // clock and reset
  input wire logic SYS_CLK, SRST,
  // register port
  input wire logic REG_WE, REG_RE,
  input wire logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA,
  // serial link
  input wire logic BCLK, FSYNC, DOUT, DOUT_OE
);
  logic seen_reg;
  logic [15:0] run_reg;
  wire logic mapped = REG_ADDR >= 8'h21 && REG_ADDR <= 8'h23;
  always_ff @(posedge SYS_CLK) begin
    seen_reg <= !SRST && (seen_reg || FSYNC);
    run_reg <= DOUT_OE ? run_reg + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  sequence write_gap_read;
    REG_WE && !REG_RE && mapped ##1 !REG_WE && !REG_RE
    ##1 REG_RE && !REG_WE && REG_ADDR == $past(REG_ADDR, 2);
  endsequence
  chk_reset_quiet: assert property (disable iff (1'b0) SRST |=> !DOUT_OE && REG_RDATA == 8'h00)
    else $error("outputs active in reset");
  chk_read_back: assert property (write_gap_read |=> REG_RDATA == ($past(REG_WDATA, 3) & 8'h7F))
    else $error("read back differs from write");
  chk_bit7_low: assert property (REG_RE |=> !REG_RDATA[7])
    else $error("bit 7 read as one");
  chk_unmapped_zero: assert property (REG_RE && !mapped |=> REG_RDATA == 8'h00)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!REG_RE |=> $stable(REG_RDATA))
    else $error("read data moved without read");
  chk_change_on_fall: assert property ($changed(DOUT) || $changed(DOUT_OE) |-> !$past(BCLK, 2) && !$past(BCLK, 3))
    else $error("data line moved outside bit clock low");
  chk_no_early_drive: assert property (!seen_reg |-> !DOUT_OE)
    else $error("drive before first frame");
  chk_slot_length: assert property ($fell(DOUT_OE) |-> run_reg >= 16'h00F0)
    else $error("drive shorter than one slot");
endmodule
bind serial_tx_channel_slot_map slot_map_props u_slot_map_props (.SYS_CLK(SYS_CLK), .SRST(SRST), .REG_WE(REG_WE),
  .REG_RE(REG_RE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .BCLK(BCLK),
  .FSYNC(FSYNC), .DOUT(DOUT), .DOUT_OE(DOUT_OE));
`default_nettype wire

// ==== testbench/host_model.sv ====
/* far side host: clocks one frame per call and captures the line
   assumes the caller waits for the task to finish */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  output logic BCLK,
  output logic FSYNC,
  input wire logic DOUT,
  input wire logic DOUT_OE
);
  logic [0:255] cap_d, cap_oe;
  initial begin
    BCLK = 0;
    FSYNC = 0;
  end
  // sync high for the first half; clock stands still outside frames
  task automatic frame(input int nbits);
    cap_oe = '0;
    #7;
    for (int i = 0; i <= nbits; i++) begin
      FSYNC = i < nbits / 2;
      #160 BCLK = 1;
      #160 BCLK = 0;
      // a released line shows the inverse of its level
      if (i > 0) begin
        cap_oe[i - 1] = DOUT_OE;
        cap_d[i - 1] = DOUT_OE ? DOUT : ~DOUT;
      end
    end
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
/* bench for the slot map: registers, buffer, TDM and LJ frames
   assumes host_model drives the link and the checker is bound */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic SYS_CLK = 0, SRST = 1, REG_WE = 0, REG_RE = 0, SRC_VALID = 0;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00;
  logic [1:0] MODE = 2'h0;
  logic [31:0] mic4_w, temp_w, loop1_w, loop2_w, echo1_w, echo2_w;
  wire logic [7:0] REG_RDATA;
  wire logic SRC_READY, BCLK, FSYNC, DOUT, DOUT_OE;
  int bad_count = 0, num_checks = 0;
  always #20 SYS_CLK = ~SYS_CLK;
  serial_tx_channel_slot_map u_serial_tx_channel_slot_map (.SYS_CLK(SYS_CLK), .SRST(SRST), .REG_WE(REG_WE),
    .REG_RE(REG_RE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .MODE(MODE),
    .SRC_VALID(SRC_VALID), .SRC_READY(SRC_READY), .SRC_MIC4(mic4_w), .SRC_TEMP(temp_w), .SRC_LOOP1(loop1_w),
    .SRC_LOOP2(loop2_w), .SRC_ECHO1(echo1_w), .SRC_ECHO2(echo2_w), .BCLK(BCLK), .FSYNC(FSYNC), .DOUT(DOUT),
    .DOUT_OE(DOUT_OE));
  host_model u_host_model (.BCLK(BCLK), .FSYNC(FSYNC), .DOUT(DOUT), .DOUT_OE(DOUT_OE));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge SYS_CLK) {REG_WE, REG_ADDR, REG_WDATA} = {1'b1, a, d};
    @(negedge SYS_CLK) REG_WE = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge SYS_CLK) {REG_RE, REG_ADDR} = {1'b1, a};
    @(negedge SYS_CLK) REG_RE = 0;
    chk({24'h00_0000, REG_RDATA}, {24'h00_0000, exp});
  endtask
  task automatic push(input logic [31:0] b);
    int n;
    for (n = 0; n < 50 && SRC_READY !== 1'b1; n++) @(negedge SYS_CLK);
    if (n == 50) begin
      bad_count++;
      close_out();
    end
    @(negedge SYS_CLK);
    mic4_w = b + 32'h1;
    temp_w = b + 32'h2;
    loop1_w = b + 32'h3;
    loop2_w = b + 32'h4;
    echo1_w = b + 32'h5;
    echo2_w = b + 32'h6;
    SRC_VALID = 1;
    @(negedge SYS_CLK) SRC_VALID = 0;
  endtask
  task automatic slot_is(input int s, input logic [31:0] exp, input logic on);
    chk(u_host_model.cap_oe[s * 32 +: 32], on ? 32'hFFFF_FFFF : 32'h0000_0000);
    if (on) chk(u_host_model.cap_d[s * 32 +: 32], exp);
  endtask
  task automatic s_regs;
    rd(8'h21, 8'h03);
    rd(8'h22, 8'h04);
    rd(8'h23, 8'h05);
    wr(8'h21, 8'hFF);
    rd(8'h21, 8'h7F);
    wr(8'h40, 8'h15);
    rd(8'h40, 8'h00);
    wr(8'h21, 8'h03);
  endtask
  task automatic s_idle;
    push(32'h1234_0000);
    u_host_model.frame(192);
    for (int s = 0; s < 6; s++) slot_is(s, 32'h0000_0000, 1'b0);
  endtask
  task automatic s_sources;
    logic [1:0] q;
    logic [31:0] b;
    for (int s = 1; s < 4; s++) begin
      q = 2'(s);
      b = {24'h5A_C3A5, 2'b00, q, 4'h0};
      wr(8'h21, {1'b0, q, 5'h03});
      wr(8'h22, {1'b0, q, 5'h04});
      wr(8'h23, {1'b0, q, 5'h05});
      push(b);
      u_host_model.frame(192);
      slot_is(3, b + 32'(q), q != 2'h3);
      slot_is(4, b + 32'h1 + 32'(2 * q), q != 2'h3);
      slot_is(5, b + 32'h2 + 32'(2 * q), q != 2'h3);
      slot_is(2, 32'h0000_0000, 1'b0);
    end
  endtask
  task automatic s_lj;
    @(negedge SYS_CLK) MODE = 2'h2;
    wr(8'h21, 8'h30);
    wr(8'h22, 8'h21);
    wr(8'h23, 8'h05);
    push(32'h0BAD_0000);
    u_host_model.frame(128);
    slot_is(2, 32'h0BAD_0001, 1'b1);
    slot_is(1, 32'h0BAD_0003, 1'b1);
    slot_is(0, 32'h0000_0000, 1'b0);
    slot_is(3, 32'h0000_0000, 1'b0);
  endtask
  task automatic s_buffer;
    @(negedge SYS_CLK) MODE = 2'h0;
    wr(8'h21, 8'h20);
    push(32'hAAAA_0000);
    push(32'hBBBB_0000);
    repeat (2) @(negedge SYS_CLK);
    chk({31'h0000_0000, SRC_READY}, 32'h0000_0000);
    u_host_model.frame(64);
    slot_is(0, 32'hAAAA_0001, 1'b1);
    u_host_model.frame(64);
    slot_is(0, 32'hBBBB_0001, 1'b1);
    u_host_model.frame(64);
    slot_is(0, 32'h0000_0000, 1'b1);
  endtask
  // i2s: left half opens on sync fall, one bit late
  task automatic s_i2s;
    @(negedge SYS_CLK) MODE = 2'h1;
    wr(8'h21, 8'h20);
    wr(8'h22, 8'h04);
    push(32'h5150_0000);
    u_host_model.frame(128);
    chk({31'h0000_0000, u_host_model.cap_oe[64]}, 32'h0000_0000);
    chk(u_host_model.cap_oe[65 +: 32], 32'hFFFF_FFFF);
    chk(u_host_model.cap_d[65 +: 32], 32'h5150_0001);
    chk({31'h0000_0000, u_host_model.cap_oe[97]}, 32'h0000_0000);
  endtask
  initial begin
    repeat (4) @(posedge SYS_CLK);
    @(negedge SYS_CLK) SRST = 0;
    s_regs();
    s_idle();
    s_sources();
    s_lj();
    s_buffer();
    s_i2s();
    close_out();
  end
endmodule
`default_nettype wire
